/* File: rtl/mrba_pkg.sv */
// Package: constants and types for the management register bit-access layer
package mrba_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int REG_WIDTH = 16;
  localparam int REG_COUNT = 32;
  localparam int IDX_WIDTH = 5;
  // ----------------------------------------
  // Bit access kinds, one code per bit
  // ----------------------------------------
  typedef enum logic [3:0] {
    MRBA_RESERVED = 4'h0,
    MRBA_READ_WRITE = 4'h1,
    MRBA_READ_ONLY = 4'h2,
    MRBA_WRITE_ONLY = 4'h3,
    MRBA_WRITE_ONE_TO_CLEAR = 4'h4,
    MRBA_WRITE_ANY_TO_CLEAR = 4'h5,
    MRBA_READ_TO_CLEAR = 4'h6,
    MRBA_LATCH_LOW = 4'h7,
    MRBA_LATCH_HIGH = 4'h8,
    MRBA_SELF_CLEARING = 4'h9,
    MRBA_SELF_SETTING = 4'hA,
    MRBA_RW_ANY_TO_CLEAR = 4'hB
  } mrba_kind_t;
  // ----------------------------------------
  // Soft reset timing
  // ----------------------------------------
  localparam int SOFT_RESET_MAX_MS = 500;
  localparam int CLK_MHZ = 100;
  localparam int SOFT_RESET_MAX_CYCLES = SOFT_RESET_MAX_MS * 1000 * CLK_MHZ;
  // Soft reset bit position in register 0
  localparam int SOFT_RESET_BIT = 15;
  localparam logic [4:0] SOFT_RESET_REG = 5'h00;
  // Hold of soft reset before self clear, cycles
  localparam int SOFT_RESET_HOLD_CYCLES = 16;
endpackage : mrba_pkg

/* File: rtl/mrba_bit_cell.sv */
// One management register bit with its configured access kind
`timescale 1ns/1ps
`default_nettype none
module mrba_bit_cell (
  // Clock and resets
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic soft_reset,
  // Static configuration
  input wire logic [3:0] kind,
  input wire logic keep_soft,
  input wire logic reset_value,
  // Access strobes for this bit's register
  input wire logic wr_en,
  input wire logic wr_bit,
  input wire logic rd_done,
  // Hardware side
  input wire logic hw_cond,
  input wire logic hw_done,
  // State
  output logic value
);
  logic value_reg;
  logic value_next;
  logic soft_hit;
  mrba_pkg::mrba_kind_t k;

  assign k = mrba_pkg::mrba_kind_t'(kind);
  assign soft_hit = soft_reset && !keep_soft;
  assign value = value_reg;

  // Next value by access kind; sets win over clears, except in self-setting, where a zero write wins over hw_done
  always_comb begin
    value_next = value_reg;
    unique case (k)
      mrba_pkg::MRBA_READ_WRITE, mrba_pkg::MRBA_WRITE_ONLY: begin
        if (wr_en) value_next = wr_bit;
      end
      mrba_pkg::MRBA_READ_ONLY: value_next = hw_cond;
      mrba_pkg::MRBA_WRITE_ONE_TO_CLEAR: begin
        if (wr_en && wr_bit) value_next = 1'b0;
        if (hw_cond) value_next = 1'b1;
      end
      mrba_pkg::MRBA_WRITE_ANY_TO_CLEAR: begin
        if (wr_en) value_next = 1'b0;
        if (hw_cond) value_next = 1'b1;
      end
      mrba_pkg::MRBA_RW_ANY_TO_CLEAR: begin
        if (wr_en) value_next = 1'b0;
        if (hw_cond) value_next = 1'b1;
      end
      mrba_pkg::MRBA_READ_TO_CLEAR: begin
        if (rd_done) value_next = 1'b0;
        if (hw_cond) value_next = 1'b1;
      end
      mrba_pkg::MRBA_LATCH_HIGH: begin
        if (rd_done) value_next = hw_cond;
        else if (hw_cond) value_next = 1'b1;
      end
      mrba_pkg::MRBA_LATCH_LOW: begin
        if (rd_done) value_next = hw_cond;
        else if (!hw_cond) value_next = 1'b0;
      end
      mrba_pkg::MRBA_SELF_CLEARING: begin
        if (wr_en && wr_bit) value_next = 1'b1;
        else if (hw_done) value_next = 1'b0;
      end
      mrba_pkg::MRBA_SELF_SETTING: begin
        if (wr_en && !wr_bit) value_next = 1'b0;
        else if (hw_done) value_next = 1'b1;
      end
      default: value_next = 1'b0;
    endcase
  end

  // Storage; hardware reset is the only way past a keep bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      value_reg <= 1'b0;
    end else if (clk_en) begin
      if (soft_hit) value_reg <= reset_value;
      else value_reg <= value_next;
    end
  end
endmodule // mrba_bit_cell
`default_nettype wire

/* File: rtl/mrba_reg_bank.sv */
// Management register bank with per-bit access semantics
//
// Notes on behaviour
// - Registers are a 32-entry set, picked by decimal index per transaction.
// - Read-only bits return their value and ignore writes.
// - Write-only bits take writes; they read as zero.
// - Writing one clears the bit; writing zero leaves it.
// - Any write clears the bit; reads show current value.
// - Read returns contents then clears them; writes do nothing.
// - Latch bits hold until their register is read; read releases.
// - Sticky-high bit stays set until read, then follows the condition.
// - Self-clearing bit returns to zero after its action; zero writes ignored.
// - Self-setting bit returns to one after clear; one writes ignored.
// - Keep-through-soft-reset bits hold value during software reset.
// - Read/write bits store writes; any-to-clear variant clears on write.
// - Soft-reset bit loads reset values into all non-kept bits, self-clears, within 0.5 s.
`timescale 1ns/1ps
`default_nettype none
module mrba_reg_bank #(
  parameter int REG_COUNT = mrba_pkg::REG_COUNT,
  parameter int SOFT_HOLD = mrba_pkg::SOFT_RESET_HOLD_CYCLES
) (
  // Clock, enable, reset
  input wire logic clk,
  input wire logic clk_en,
  input wire logic reset_n,
  // Management access from frame engine
  input wire logic [4:0] acc_index,
  input wire logic acc_read,
  input wire logic acc_write,
  input wire logic [15:0] acc_wdata,
  output logic [15:0] acc_rdata,
  output logic acc_rvalid,
  // Per-bit static configuration
  input wire logic [REG_COUNT*64-1:0] bit_kind,
  input wire logic [REG_COUNT*16-1:0] bit_keep_soft,
  input wire logic [REG_COUNT*16-1:0] bit_reset_value,
  // Device core side
  input wire logic [REG_COUNT*16-1:0] hw_cond,
  input wire logic [REG_COUNT*16-1:0] hw_done,
  output logic [REG_COUNT*16-1:0] reg_value,
  output logic soft_reset_active
);
  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic [REG_COUNT-1:0] sel;
  logic [15:0] rdata_reg;
  logic rvalid_reg;
  logic [4:0] soft_cnt_reg;
  logic soft_active_reg;
  logic soft_req;
  logic soft_pulse;
  logic [15:0] reg_rd_view;

  // Reserved and write-only bits read as zero
  function automatic logic [15:0] read_view(input logic [15:0] v, input logic [63:0] kinds);
    logic [15:0] r;
    r = 16'h0000;
    for (int b = 0; b < 16; b++) begin
      if (kinds[b*4 +: 4] != 4'h0 && kinds[b*4 +: 4] != 4'h3) r[b] = v[b];
    end
    return r;
  endfunction

  genvar gr, gb;
  generate
    for (gr = 0; gr < REG_COUNT; gr++) begin : g_reg
      assign sel[gr] = (acc_index == 5'(gr));
      for (gb = 0; gb < 16; gb++) begin : g_bit
        mrba_bit_cell u_cell (
          .clk(clk),
          .reset_n(reset_n),
          .clk_en(clk_en),
          .soft_reset(soft_pulse),
          .kind(bit_kind[(gr*16+gb)*4 +: 4]),
          .keep_soft(bit_keep_soft[gr*16+gb]),
          .reset_value(bit_reset_value[gr*16+gb]),
          .wr_en(acc_write && sel[gr]),
          .wr_bit(acc_wdata[gb]),
          .rd_done(acc_read && sel[gr]),
          .hw_cond(hw_cond[gr*16+gb]),
          .hw_done(hw_done[gr*16+gb] || (gr == 0 && gb == mrba_pkg::SOFT_RESET_BIT && soft_pulse)),
          .value(reg_value[gr*16+gb])
        );
      end
    end
  endgenerate

  // Read mux; index beyond the set reads zero
  assign reg_rd_view = (32'(acc_index) < REG_COUNT) ?
    read_view(reg_value[acc_index*16 +: 16], bit_kind[acc_index*64 +: 64]) : 16'h0000;

  // soft reset request from control bit
  assign soft_req = acc_write && (acc_index == mrba_pkg::SOFT_RESET_REG)
    && acc_wdata[mrba_pkg::SOFT_RESET_BIT];
  assign soft_pulse = soft_active_reg && (soft_cnt_reg == 5'h01);
  assign soft_reset_active = soft_active_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else if (clk_en) begin
      rvalid_reg <= acc_read;
      if (acc_read) rdata_reg <= reg_rd_view;
    end
  end

  // bounded soft reset sequence, well inside 0.5 s
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_active_reg <= 1'b0;
      soft_cnt_reg <= 5'h00;
    end else if (clk_en) begin
      if (soft_req && !soft_active_reg) begin
        soft_active_reg <= 1'b1;
        soft_cnt_reg <= 5'(SOFT_HOLD);
      end else if (soft_active_reg) begin
        soft_cnt_reg <= soft_cnt_reg - 5'h01;
        if (soft_cnt_reg == 5'h01) soft_active_reg <= 1'b0;
      end
    end
  end

  assign acc_rdata = rdata_reg;
  assign acc_rvalid = rvalid_reg;
endmodule // mrba_reg_bank
`default_nettype wire

/* File: test/mrba_reg_bank_properties.sv */
// Checker of bit access behaviour at the register bank ports
`timescale 1ns/1ps
`default_nettype none
module mrba_reg_bank_chk #(
  parameter int REG_COUNT = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic clk_en,
  input wire logic reset_n,
  // Access port
  input wire logic [4:0] acc_index,
  input wire logic acc_read,
  input wire logic acc_write,
  input wire logic [15:0] acc_wdata,
  input wire logic [15:0] acc_rdata,
  input wire logic acc_rvalid,
  // Core side
  input wire logic [REG_COUNT*16-1:0] hw_cond,
  input wire logic [REG_COUNT*16-1:0] reg_value,
  input wire logic soft_reset_active
);
  // Register 1 holds one bit of each kind
  wire w1 = clk_en && acc_write && acc_index == 5'h01;
  wire r1 = clk_en && acc_read && acc_index == 5'h01;
  wire [15:0] v = reg_value[31:16];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  rvalid_pulse_a: assert property ($past(clk_en) && acc_rvalid |-> $past(acc_read))
    else $error("read answer without a request");
  read_back_a: assert property (r1 |=> acc_rvalid && acc_rdata[0] == $past(v[0]))
    else $error("read data differs from stored bit");
  rw_write_a: assert property (w1 && !soft_reset_active |=> v[0] == $past(acc_wdata[0]))
    else $error("written bit not stored");
  one_clears_a: assert property (w1 && acc_wdata[3] && !hw_cond[19] |=> !v[3])
    else $error("write of one did not clear");
  any_clears_a: assert property (w1 && !hw_cond[20] |=> !v[4])
    else $error("write did not clear");
  read_clears_a: assert property (r1 && !hw_cond[21] |=> !v[5] && acc_rdata[5] == $past(v[5]))
    else $error("read did not return then clear");
  sticky_high_a: assert property (v[7] && !r1 && !soft_reset_active |=> v[7])
    else $error("sticky high bit dropped before read");
  latch_low_a: assert property (!v[6] && !r1 && !soft_reset_active |=> !v[6])
    else $error("latched low bit rose before read");
  soft_keep_a: assert property (soft_reset_active && !w1 |=> v[11] == $past(v[11]))
    else $error("kept bit changed in soft reset");
  soft_end_a: assert property ($rose(soft_reset_active) |-> ##[1:20] !soft_reset_active && !reg_value[15])
    else $error("soft reset did not finish");
endmodule // mrba_reg_bank_chk
bind mrba_reg_bank mrba_reg_bank_chk #(.REG_COUNT(REG_COUNT)) u_chk (.clk(clk), .clk_en(clk_en),
  .reset_n(reset_n), .acc_index(acc_index), .acc_read(acc_read), .acc_write(acc_write), .acc_wdata(acc_wdata),
  .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .hw_cond(hw_cond), .reg_value(reg_value),
  .soft_reset_active(soft_reset_active));
`default_nettype wire

/* File: test/mrba_smc_model.sv */
// Behavioural management controller issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module mrba_smc_model (
  // Clock
  input wire logic clk,
  // Requests
  output logic [4:0] acc_index,
  output logic acc_read,
  output logic acc_write,
  output logic [15:0] acc_wdata,
  // Answer
  input wire logic [15:0] acc_rdata,
  input wire logic acc_rvalid
);
  // Idle bus at time zero
  initial begin
    acc_index = 5'h00;
    acc_read = 1'b0;
    acc_write = 1'b0;
    acc_wdata = 16'h0000;
  end
  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    @(posedge clk);
    #1;
    acc_index = i;
    acc_wdata = d;
    acc_write = 1'b1;
    @(posedge clk);
    #1;
    acc_write = 1'b0;
    acc_wdata = ~d; // Released data must not look valid
  endtask
  // Read answer comes one cycle after the request edge
  task automatic rd(input logic [4:0] i, output logic [15:0] d);
    @(posedge clk);
    #1;
    acc_index = i;
    acc_read = 1'b1;
    @(posedge clk);
    #1;
    acc_read = 1'b0;
    d = acc_rvalid ? acc_rdata : 16'hXXXX;
  endtask
endmodule // mrba_smc_model
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the register bank bit access kinds
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] cond = 16'h0000;
  logic [15:0] done = 16'h0000;
  logic [4:0] acc_index;
  logic acc_read, acc_write, acc_rvalid, soft_reset_active;
  logic [15:0] acc_wdata, acc_rdata, rd_data;
  logic [31:0] reg_value;
  int fails = 0;
  int n_tests = 0;
  // Register 1 rows: write flag, data, condition, mask, expected
  // Last three rows: any-write clear after a hardware set, then ones written to read-only kinds
  logic [67:0] rows [0:8] = '{68'h1_0801_00FA_0000_0000, 68'h0_0000_0040_08F9_08B9,
    68'h0_0000_0040_08F9_0859, 68'h1_0008_0000_0000_0000, 68'h0_0000_0002_08F9_0000, 68'h0_0000_0002_08FB_0002,
    68'h0_0000_0400_0402_0400, 68'h1_04E2_0000_0000_0000, 68'h0_0000_0000_04E2_0000};
  always #5 clk = ~clk;
  // Two registers keep the vectors short; bit 11 of register 1 is kept
  mrba_reg_bank #(.REG_COUNT(2), .SOFT_HOLD(4)) uut (.clk(clk), .clk_en(clk_en), .reset_n(reset_n),
    .acc_index(acc_index), .acc_read(acc_read), .acc_write(acc_write), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .bit_kind({64'h0000_1BA9_8765_4321, 64'h9000_0000_0000_0000}),
    .bit_keep_soft(32'h0800_0000), .bit_reset_value(32'h0000_0000), .hw_cond({cond, 16'h0000}),
    .hw_done({done, 16'h0000}), .reg_value(reg_value), .soft_reset_active(soft_reset_active));
  mrba_smc_model smc (.clk(clk), .acc_index(acc_index), .acc_read(acc_read), .acc_write(acc_write),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));
  task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog, far beyond the roughly 40 cycles needed
  initial begin
    #20000;
    fails++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    foreach (rows[k]) begin
      cond = rows[k][47:32];
      if (rows[k][64]) begin
        smc.wr(5'h01, rows[k][63:48]);
      end else begin
        smc.rd(5'h01, rd_data);
        chk16("row", rows[k][15:0], rd_data & rows[k][31:16]);
      end
    end
    smc.wr(5'h01, 16'h0100);
    chk16("sc_set", 16'h0100, reg_value[31:16] & 16'h0300);
    done = 16'h0300;
    @(posedge clk);
    #1;
    done = 16'h0000;
    chk16("sc_ss_done", 16'h0200, reg_value[31:16] & 16'h0300);
    smc.wr(5'h01, 16'h0100);
    smc.wr(5'h01, 16'h0200);
    chk16("sc_ss_keep", 16'h0100, reg_value[31:16] & 16'h0300);
    smc.wr(5'h01, 16'h0801);
    smc.wr(5'h00, 16'h8000);
    chk16("soft_on", 16'h8001, {reg_value[15], 14'h0000, soft_reset_active});
    for (int k = 0; k < 20 && soft_reset_active === 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk16("soft_end", 16'h0000, {reg_value[15], 14'h0000, soft_reset_active});
    chk16("soft_keep", 16'h0800, reg_value[31:16] & 16'h0801);
    // Enable low: a write must not be taken
    clk_en = 1'b0;
    smc.wr(5'h01, 16'h0000);
    chk16("frozen", 16'h0800, reg_value[31:16] & 16'h0801);
    clk_en = 1'b1;
    smc.rd(5'h05, rd_data);
    chk16("unmapped", 16'h0000, rd_data);
    // Hardware reset in mid-run clears kept bits too
    reset_n = 1'b0;
    #1;
    chk16("hw_reset", 16'h0000, reg_value[31:16] | {15'h0000, acc_rvalid});
    test_done();
  end
endmodule // tb_top
`default_nettype wire
